// *** logic/tcw_params.svh ***
// constants of the timer, cascade and watchdog block
`ifndef TCW_PARAMS_SVH
`define TCW_PARAMS_SVH
`define TCW_CLK_MHZ      100
`define TCW_OSC_PER_MC   12
`define TCW_PH_S3P1      4'h4
`define TCW_PH_S5P1      4'h8
`define TCW_PH_S5P2      4'h9
`define TCW_WD_RESET_MC  3'h5
`define TCW_RST_BYTE     8'h00
`define TCW_A_T2CTL      8'h00
`define TCW_A_EXT        8'h01
`define TCW_A_T2LO       8'h02
`define TCW_A_T2HI       8'h03
`define TCW_A_CAPLO      8'h04
`define TCW_A_CAPHI      8'h05
`define TCW_A_TMODE      8'h06
`define TCW_A_TCTL       8'h07
`define TCW_A_TLO0       8'h08
`define TCW_TCTL_HF      7
`define TCW_TCTL_HR      6
`define TCW_TCTL_LF      5
`define TCW_TCTL_LR      4
`endif

// *** logic/tcw_pkg.sv ***
// types of the timer, cascade and watchdog block
package tcw_pkg;
  typedef enum logic [3:0] {
    TCW_OFF     = 4'b0001,
    TCW_CAPTURE = 4'b0010,
    TCW_RELOAD  = 4'b0100,
    TCW_BAUD    = 4'b1000
  } tcw_mode_e;
  typedef struct packed {
    logic third_overflow_flag;
    logic third_trigger_flag;
    logic rx_baud_select;
    logic tx_baud_select;
    logic trigger_enable;
    logic third_run;
    logic third_counter_select;
    logic capture_reload_select;
  } tcw_t2ctl_s;
  typedef struct packed {
    logic       watchdog_enable;
    logic       cascade_enable;
    logic [5:0] port_bits;
  } tcw_ext_s;
  typedef struct packed {
    logic       gate;
    logic       counter_select;
    logic [1:0] mode;
  } tcw_half_s;
  typedef struct packed {
    tcw_half_s high;
    tcw_half_s low;
  } tcw_tmode_s;
endpackage : tcw_pkg

// *** logic/tcw_timer.sv ***
// timer subsystem: third timer, 32-bit cascade and watchdog
`include "tcw_params.svh"
`timescale 1ns/1ps
`default_nettype none
module tcw_timer (
  // clock and reset
  input  wire logic       i_clock,
  input  wire logic       i_rst,
  // register port
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  // pins and chip state
  input  wire logic       i_count_input_zero,
  input  wire logic       i_count_input_one,
  input  wire logic       i_third_count_input,
  input  wire logic       i_trigger_input,
  input  wire logic       i_power_down_bit,
  // results
  output logic            o_cpu_reset,
  output logic            o_rx_baud_tick,
  output logic            o_tx_baud_tick,
  output logic            o_third_irq,
  output logic            o_low_irq,
  output logic            o_high_irq
);
  localparam logic [3:0] PH_LAST = 4'(`TCW_OSC_PER_MC - 1);

  tcw_pkg::tcw_t2ctl_s t2ctl_reg, t2ctl_next;
  tcw_pkg::tcw_ext_s   ext_reg;
  tcw_pkg::tcw_tmode_s tmode_reg;
  tcw_pkg::tcw_mode_e  mode;
  logic [7:0]  tctl_reg, tctl_next;
  logic [15:0] t2_reg, t2_next;
  logic [15:0] cap_reg, cap_next;
  logic [3:0]  phase_reg;
  logic [7:0]  rdata_reg;
  logic [7:0]  rd_mux;
  logic [7:0]  tlo    [2];
  logic [7:0]  thi    [2];
  logic [1:0]  en, ovf, tick;
  logic [3:0]  pins, fall;
  logic        pd, s3p1, s5p1, s5p2, casc, casc_tick;
  logic        carry0, casc_pend_reg, rst_blk, baud, t2_tick, t2_ovf;
  logic        trig_ev, lf_set, hf_set, wd_arm_reg, wd_rst_reg;
  logic [2:0]  wd_cnt_reg;
  logic        rx_reg, tx_reg, irq2_reg, irq0_reg, irq1_reg;

  // the oscillator stops in power-down, so the phase freezes
  assign pd      = i_power_down_bit;
  assign rst_blk = i_rst | wd_rst_reg;
  assign s3p1    = !pd && phase_reg == `TCW_PH_S3P1;
  assign s5p1    = !pd && phase_reg == `TCW_PH_S5P1;
  assign s5p2    = !pd && phase_reg == `TCW_PH_S5P2;

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      phase_reg <= 4'h0;
    end else if (!pd) begin
      phase_reg <= (phase_reg == PH_LAST) ? 4'h0 : 4'(phase_reg + 4'h1);
    end
  end

  // edge sensing on the four pins; a period under two machine cycles is lost
  assign pins = {i_trigger_input, i_third_count_input,
                 i_count_input_one, i_count_input_zero};
  for (genvar k = 0; k < 4; k++) begin : g_pin
    logic last_reg;
    logic se;
    // pins zero and one keep sampling in power-down
    assign se = s5p2 | (pd & (k < 2));
    assign fall[k] = se & last_reg & !pins[k];
    always_ff @(posedge i_clock) begin
      if (rst_blk) begin
        last_reg <= 1'b0;
      end else if (se) begin
        last_reg <= pins[k];
      end
    end
  end

  // timers zero and one, alone or cascaded
  assign casc = ext_reg.cascade_enable;
  always_comb begin
    tick[0] = tmode_reg.low.counter_select ? fall[0] : s3p1;
    tick[1] = tmode_reg.high.counter_select ? fall[1] : s3p1;
    casc_tick = tick[0];
    carry0 = &{thi[0], tlo[0]};
    if (casc) begin
      en[0] = casc_tick;
      en[1] = casc_tick & carry0;
    end else begin
      en[0] = tctl_reg[`TCW_TCTL_LR] & tick[0];
      en[1] = tctl_reg[`TCW_TCTL_HR] & tick[1];
    end
  end

  for (genvar i = 0; i < 2; i++) begin : g_tm
    logic [7:0] tlo_reg;
    logic [7:0] thi_reg;
    logic [7:0] tlo_next;
    logic [7:0] thi_next;
    logic [1:0] m;
    logic       ovf_c;
    assign tlo[i] = tlo_reg;
    assign thi[i] = thi_reg;
    assign ovf[i] = ovf_c;
    always_comb begin
      if (casc) begin
        m = 2'h1;
      end else if (i == 0) begin
        m = tmode_reg.low.mode;
      end else begin
        m = tmode_reg.high.mode;
      end
      tlo_next = tlo_reg;
      thi_next = thi_reg;
      ovf_c    = 1'b0;
      if (en[i]) begin
        case (m)
          2'h0: begin
            {thi_next, tlo_next[4:0]} =
              13'({thi_reg, tlo_reg[4:0]} + 13'h1);
            ovf_c = &{thi_reg, tlo_reg[4:0]};
          end
          2'h1: begin
            {thi_next, tlo_next} = 16'({thi_reg, tlo_reg} + 16'h1);
            ovf_c = &{thi_reg, tlo_reg};
          end
          2'h2: begin
            tlo_next = (&tlo_reg) ? thi_reg : 8'(tlo_reg + 8'h1);
            ovf_c    = &tlo_reg;
          end
          default: begin
            ovf_c = 1'b0;
          end
        endcase
      end
    end
    always_ff @(posedge i_clock) begin
      if (rst_blk) begin
        tlo_reg <= `TCW_RST_BYTE;
        thi_reg <= `TCW_RST_BYTE;
      end else begin
        if (i_wr && i_addr == 8'(`TCW_A_TLO0 + 2 * i)) begin
          tlo_reg <= i_wdata;
        end else begin
          tlo_reg <= tlo_next;
        end
        if (i_wr && i_addr == 8'(`TCW_A_TLO0 + 2 * i + 1)) begin
          thi_reg <= i_wdata;
        end else begin
          thi_reg <= thi_next;
        end
      end
    end
  end

  // in cascade the low carry never flags; 32-bit overflow waits for S5P1, or sets at once in power-down
  assign lf_set = ovf[0] & !casc;
  assign hf_set = (!casc & ovf[1]) | (casc_pend_reg & (s5p1 | pd));

  always_ff @(posedge i_clock) begin
    if (rst_blk) begin
      casc_pend_reg <= 1'b0;
    end else if (casc & ovf[1]) begin
      casc_pend_reg <= 1'b1;
    end else if (hf_set) begin
      casc_pend_reg <= 1'b0;
    end
  end

  // a flag set by hardware beats a software clear in the same cycle
  always_comb begin
    tctl_next = tctl_reg;
    if (i_wr && i_addr == `TCW_A_TCTL) begin
      tctl_next = i_wdata;
    end
    if (lf_set) begin
      tctl_next[`TCW_TCTL_LF] = 1'b1;
    end
    if (hf_set) begin
      tctl_next[`TCW_TCTL_HF] = 1'b1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (rst_blk) begin
      tctl_reg  <= `TCW_RST_BYTE;
      tmode_reg <= tcw_pkg::tcw_tmode_s'(`TCW_RST_BYTE);
      ext_reg   <= tcw_pkg::tcw_ext_s'(`TCW_RST_BYTE);
    end else begin
      tctl_reg <= tctl_next;
      if (i_wr && i_addr == `TCW_A_TMODE) begin
        tmode_reg <= tcw_pkg::tcw_tmode_s'(i_wdata);
      end
      if (i_wr && i_addr == `TCW_A_EXT) begin
        ext_reg <= tcw_pkg::tcw_ext_s'(i_wdata);
      end
    end
  end

  // watchdog: high flag setting arms a five machine cycle reset
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      wd_arm_reg <= 1'b0;
      wd_rst_reg <= 1'b0;
      wd_cnt_reg <= 3'h0;
    end else if (wd_rst_reg) begin
      if (!pd && phase_reg == PH_LAST) begin
        if (wd_cnt_reg == 3'h0) begin
          wd_rst_reg <= 1'b0;
        end else begin
          wd_cnt_reg <= 3'(wd_cnt_reg - 3'h1);
        end
      end
    end else begin
      if (ext_reg.watchdog_enable & hf_set) begin
        wd_arm_reg <= 1'b1;
      end
      // the reset opens at the next machine cycle boundary, or at once in power-down
      if (wd_arm_reg && (pd || phase_reg == PH_LAST)) begin
        wd_arm_reg <= 1'b0;
        wd_rst_reg <= 1'b1;
        wd_cnt_reg <= 3'(`TCW_WD_RESET_MC - 3'h1);
      end
    end
  end

  // third timer
  assign baud = t2ctl_reg.rx_baud_select | t2ctl_reg.tx_baud_select;
  always_comb begin
    if (!t2ctl_reg.third_run) begin
      mode = tcw_pkg::TCW_OFF;
    end else if (baud) begin
      mode = tcw_pkg::TCW_BAUD;
    end else if (t2ctl_reg.capture_reload_select) begin
      mode = tcw_pkg::TCW_CAPTURE;
    end else begin
      mode = tcw_pkg::TCW_RELOAD;
    end
  end

  assign t2_tick = (mode != tcw_pkg::TCW_OFF) &
    (t2ctl_reg.third_counter_select ? fall[2] : s3p1);
  assign t2_ovf  = t2_tick & (&t2_reg);
  assign trig_ev = fall[3] & t2ctl_reg.trigger_enable &
    (mode == tcw_pkg::TCW_CAPTURE || mode == tcw_pkg::TCW_RELOAD);

  always_comb begin
    t2_next  = t2_reg;
    cap_next = cap_reg;
    case (mode)
      tcw_pkg::TCW_CAPTURE: begin
        if (t2_tick) begin
          t2_next = 16'(t2_reg + 16'h1);
        end
        if (trig_ev) begin
          cap_next = t2_reg;
        end
      end
      tcw_pkg::TCW_RELOAD: begin
        if (t2_ovf | trig_ev) begin
          t2_next = cap_reg;
        end else if (t2_tick) begin
          t2_next = 16'(t2_reg + 16'h1);
        end
      end
      tcw_pkg::TCW_BAUD: begin
        if (t2_ovf) begin
          t2_next = cap_reg;
        end else if (t2_tick) begin
          t2_next = 16'(t2_reg + 16'h1);
        end
      end
      default: begin
        t2_next = t2_reg;
      end
    endcase
    if (i_wr && i_addr == `TCW_A_T2LO) begin
      t2_next[7:0] = i_wdata;
    end
    if (i_wr && i_addr == `TCW_A_T2HI) begin
      t2_next[15:8] = i_wdata;
    end
    if (i_wr && i_addr == `TCW_A_CAPLO) begin
      cap_next[7:0] = i_wdata;
    end
    if (i_wr && i_addr == `TCW_A_CAPHI) begin
      cap_next[15:8] = i_wdata;
    end
  end

  always_comb begin
    t2ctl_next = t2ctl_reg;
    if (i_wr && i_addr == `TCW_A_T2CTL) begin
      t2ctl_next = tcw_pkg::tcw_t2ctl_s'(i_wdata);
    end
    if (t2_ovf & !baud) begin
      t2ctl_next.third_overflow_flag = 1'b1;
    end
    if (trig_ev) begin
      t2ctl_next.third_trigger_flag = 1'b1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (rst_blk) begin
      t2ctl_reg <= tcw_pkg::tcw_t2ctl_s'(`TCW_RST_BYTE);
      t2_reg    <= {2{`TCW_RST_BYTE}};
      cap_reg   <= {2{`TCW_RST_BYTE}};
    end else begin
      t2ctl_reg <= t2ctl_next;
      t2_reg    <= t2_next;
      cap_reg   <= cap_next;
    end
  end

  // baud ticks and interrupt requests, one cycle behind their cause
  always_ff @(posedge i_clock) begin
    if (rst_blk) begin
      rx_reg   <= 1'b0;
      tx_reg   <= 1'b0;
      irq2_reg <= 1'b0;
      irq0_reg <= 1'b0;
      irq1_reg <= 1'b0;
    end else begin
      rx_reg   <= t2ctl_reg.rx_baud_select ? t2_ovf : ovf[1];
      tx_reg   <= t2ctl_reg.tx_baud_select ? t2_ovf : ovf[1];
      irq2_reg <= t2ctl_reg.third_overflow_flag |
                  t2ctl_reg.third_trigger_flag;
      irq0_reg <= tctl_reg[`TCW_TCTL_LF];
      irq1_reg <= tctl_reg[`TCW_TCTL_HF];
    end
  end

  // register read, data in the following cycle only
  always_comb begin
    case (i_addr)
      `TCW_A_T2CTL: rd_mux = t2ctl_reg;
      `TCW_A_EXT:   rd_mux = ext_reg;
      `TCW_A_T2LO:  rd_mux = t2_reg[7:0];
      `TCW_A_T2HI:  rd_mux = t2_reg[15:8];
      `TCW_A_CAPLO: rd_mux = cap_reg[7:0];
      `TCW_A_CAPHI: rd_mux = cap_reg[15:8];
      `TCW_A_TMODE: rd_mux = tmode_reg;
      `TCW_A_TCTL:  rd_mux = tctl_reg;
      8'(`TCW_A_TLO0):     rd_mux = tlo[0];
      8'(`TCW_A_TLO0 + 1): rd_mux = thi[0];
      8'(`TCW_A_TLO0 + 2): rd_mux = tlo[1];
      8'(`TCW_A_TLO0 + 3): rd_mux = thi[1];
      default:      rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= i_rd ? rd_mux : 8'h00;
    end
  end

  assign o_rdata        = rdata_reg;
  assign o_cpu_reset    = wd_rst_reg;
  assign o_rx_baud_tick = rx_reg;
  assign o_tx_baud_tick = tx_reg;
  assign o_third_irq    = irq2_reg;
  assign o_low_irq      = irq0_reg;
  assign o_high_irq     = irq1_reg;
endmodule : tcw_timer
`default_nettype wire

// *** bench/tcw_src.sv ***
// count and trigger sources on the far side of the timer block
`timescale 1ns/1ps
`default_nettype none
module tcw_src (
  // clock
  input  wire logic       i_clock,
  // commands per line: free run or one low pulse
  input  wire logic [3:0] i_run,
  input  wire logic [3:0] i_pulse,
  // lines: zero, one, third count, trigger
  output var  logic [3:0] o_line
);
  logic [5:0] cnt_reg [4];
  initial begin
    o_line = 4'hF;
    for (int g = 0; g < 4; g++) cnt_reg[g] = 6'h00;
  end
  // low 24 clocks then high 24: period of four machine cycles
  always @(posedge i_clock) begin
    for (int g = 0; g < 4; g++) begin
      if (i_pulse[g] || (i_run[g] && cnt_reg[g] == 6'h00)) begin
        o_line[g]  <= 1'b0;
        cnt_reg[g] <= 6'h2F;
      end else if (cnt_reg[g] != 6'h00) begin
        cnt_reg[g] <= cnt_reg[g] - 6'h01;
        if (cnt_reg[g] == 6'h18) o_line[g] <= 1'b1;
      end
    end
  end
endmodule : tcw_src
`default_nettype wire

// *** bench/tcw_timer_props.sv ***
// port assertions of the timer block
`timescale 1ns/1ps
`default_nettype none
module tcw_timer_props (
  // clock and reset
  input wire logic       i_clock,
  input wire logic       i_rst,
  // register port
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] o_rdata,
  // results
  input wire logic       o_cpu_reset,
  input wire logic       o_rx_baud_tick,
  input wire logic       o_tx_baud_tick,
  input wire logic       o_third_irq,
  input wire logic       o_high_irq
);
  logic [7:0] ext_reg;
  logic [6:0] hold_reg;
  logic       quiet_reg;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  // watchdog reset wipes the copy like the real register
  always_ff @(posedge i_clock) begin
    if (i_rst || o_cpu_reset) ext_reg <= 8'h00;
    else if (i_wr && i_addr == 8'h01) ext_reg <= i_wdata;
  end
  always_ff @(posedge i_clock) begin
    if (i_rst || !o_cpu_reset) hold_reg <= 7'h00;
    else hold_reg <= hold_reg + 7'h01;
  end
  // baud mode entered with both flags cleared
  always_ff @(posedge i_clock) begin
    if (i_rst || o_cpu_reset) quiet_reg <= 1'b0;
    else if (i_wr && i_addr == 8'h00)
      quiet_reg <= i_wdata[7:6] == 2'h0 && i_wdata[5:4] != 2'h0;
  end
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data outside its cycle");
  a_rdata_unmapped: assert property (
    $past(i_rd) && $past(i_addr) > 8'h0B |-> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_ext_readback: assert property ($past(i_rd) && $past(i_addr) == 8'h01
    && !$past(o_cpu_reset) |-> o_rdata == $past(ext_reg))
    else $error("extension register readback wrong");
  a_rx_tick_pulse: assert property (o_rx_baud_tick |=> !o_rx_baud_tick)
    else $error("receive tick longer than one cycle");
  a_tx_tick_pulse: assert property (o_tx_baud_tick |=> !o_tx_baud_tick)
    else $error("transmit tick longer than one cycle");
  a_wd_len_max: assert property (o_cpu_reset |-> hold_reg < 7'h3C)
    else $error("watchdog reset too long");
  a_wd_len_end: assert property ($fell(o_cpu_reset) |-> hold_reg == 7'h3C)
    else $error("watchdog reset too short");
  a_wd_cause: assert property ($rose(o_cpu_reset) |-> $past(ext_reg[7]))
    else $error("reset without watchdog enable");
  a_wd_follows: assert property (
    $rose(o_high_irq) && ext_reg[7] |-> ##[0:13] $rose(o_cpu_reset))
    else $error("watchdog overflow gave no reset");
  a_baud_no_flag: assert property (
    quiet_reg && $past(quiet_reg) && $past(quiet_reg, 2) |-> !o_third_irq)
    else $error("third timer flag set in baud mode");
  c_wd: cover property ($rose(o_cpu_reset));
  c_rx: cover property (o_rx_baud_tick);
  c_tx: cover property (o_tx_baud_tick);
  c_irq: cover property ($rose(o_third_irq));
endmodule : tcw_timer_props
bind tcw_timer tcw_timer_props u_props (.i_clock, .i_rst, .i_addr,
  .i_wdata, .i_wr, .i_rd, .o_rdata, .o_cpu_reset, .o_rx_baud_tick,
  .o_tx_baud_tick, .o_third_irq, .o_high_irq);
`default_nettype wire

// *** bench/tb_top.sv ***
// self-checking bench of the timer block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        i_clock;
  logic        i_rst;
  logic [7:0]  i_addr;
  logic [7:0]  i_wdata;
  logic        i_wr;
  logic        i_rd;
  logic        i_power_down_bit;
  logic [7:0]  o_rdata;
  logic        o_cpu_reset;
  logic        o_rx_baud_tick;
  logic        o_tx_baud_tick;
  logic        o_third_irq;
  logic        o_low_irq;
  logic        o_high_irq;
  logic [3:0]  src_run;
  logic [3:0]  src_pulse;
  logic [3:0]  src_line;
  logic [15:0] v;
  logic [15:0] r;
  logic [7:0]  c;
  int          errors;
  int          checks_done;
  int          cycles;
  int          n_rx;
  int          n_tx;
  int          n;
  tcw_src SRC (.i_clock, .i_run(src_run), .i_pulse(src_pulse),
    .o_line(src_line));
  tcw_timer DUT (.i_clock, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd,
    .o_rdata, .i_count_input_zero(src_line[0]),
    .i_count_input_one(src_line[1]), .i_third_count_input(src_line[2]),
    .i_trigger_input(src_line[3]), .i_power_down_bit, .o_cpu_reset,
    .o_rx_baud_tick, .o_tx_baud_tick, .o_third_irq, .o_low_irq,
    .o_high_irq);
  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end
  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test
  // hang guard, and baud tick counting
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (o_rx_baud_tick === 1'b1) n_rx <= n_rx + 1;
    if (o_tx_baud_tick === 1'b1) n_tx <= n_tx + 1;
    if (cycles == 20000) begin
      errors = errors + 1;
      stop_test();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rck(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_clock);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_rd <= 1'b0;
    @(negedge i_clock);
    chk({8'h00, o_rdata}, {8'h00, e});
  endtask : rck
  task automatic w16(input logic [7:0] a, input logic [15:0] d);
    wr(a, d[7:0]);
    wr(a + 8'h01, d[15:8]);
  endtask : w16
  task automatic r16(input logic [7:0] a, input logic [15:0] e);
    rck(a, e[7:0]);
    rck(a + 8'h01, e[15:8]);
  endtask : r16
  task automatic pulse(input int g, input int w);
    @(posedge i_clock);
    src_pulse[g] <= 1'b1;
    @(posedge i_clock);
    src_pulse[g] <= 1'b0;
    repeat (w) @(posedge i_clock);
  endtask : pulse
  // count after one input edge from FFFF
  function automatic logic [15:0] exp_cnt(input logic [7:0] ct,
                                          input logic [15:0] rl);
    return !ct[2] ? 16'hFFFF : (ct[0] ? 16'h0000 : rl);
  endfunction : exp_cnt
  // window edges may gain or lose one tick
  function automatic logic [15:0] in_band(input int k, input int e);
    return 16'((e == 0) ? (k == 0) : (k >= e - 1 && k <= e + 1));
  endfunction : in_band
  logic [7:0] ovf [3] = '{8'h07, 8'h06, 8'h03};
  logic [7:0] baud [4] = '{8'h34, 8'h35, 8'h24, 8'h14};
  initial begin
    errors = 0;
    checks_done = 0;
    cycles = 0;
    n_rx = 0;
    n_tx = 0;
    i_rst = 1'b1;
    i_addr = 8'h00;
    i_wdata = 8'h00;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_power_down_bit = 1'b0;
    src_run = 4'h0;
    src_pulse = 4'h0;
    v = 16'($urandom(32'h1E1C4428));
    repeat (8) @(posedge i_clock);
    i_rst <= 1'b0;
    for (int a = 0; a < 12; a++) rck(8'(a), 8'h00);
    rck(8'h3C, 8'h00);
    for (int i = 0; i < 4; i++) begin
      v = 16'($urandom);
      wr(8'h01, {2'h0, v[5:0]});
      rck(8'h01, {2'h0, v[5:0]});
      w16(8'h04, v);
      r16(8'h04, v);
    end
    v = 16'($urandom);
    r = 16'($urandom);
    w16(8'h02, v);
    wr(8'h00, 8'h0F);
    pulse(3, 48);
    r16(8'h04, v);
    rck(8'h00, 8'h4F);
    chk({15'h0000, o_third_irq}, 16'h0001);
    wr(8'h00, 8'h07);
    w16(8'h02, r);
    pulse(3, 48);
    r16(8'h04, v);
    rck(8'h00, 8'h07);
    w16(8'h04, r);
    w16(8'h02, v);
    wr(8'h00, 8'h0E);
    pulse(3, 48);
    r16(8'h02, r);
    rck(8'h00, 8'h4E);
    foreach (ovf[i]) begin
      wr(8'h00, 8'h00);
      w16(8'h02, 16'hFFFF);
      wr(8'h00, ovf[i]);
      pulse(2, 48);
      r16(8'h02, exp_cnt(ovf[i], r));
      rck(8'h00, {ovf[i][2], ovf[i][6:0]});
      wr(8'h00, ovf[i]);
      rck(8'h00, ovf[i]);
    end
    foreach (baud[i]) begin
      c = baud[i];
      wr(8'h00, 8'h00);
      w16(8'h04, 16'hFFF0);
      w16(8'h02, 16'hFFF0);
      wr(8'h00, c);
      @(negedge i_clock);
      n_rx = 0;
      n_tx = 0;
      repeat (776) @(posedge i_clock);
      n = 776 / (12 * (65536 - 16'hFFF0));
      chk(in_band(n_rx, c[5] ? n : 0), 16'h0001);
      chk(in_band(n_tx, c[4] ? n : 0), 16'h0001);
      rck(8'h00, c);
    end
    wr(8'h00, 8'h00);
    wr(8'h06, 8'h04);
    for (int k = 0; k < 3; k++) begin
      wr(8'h07, 8'h00);
      w16(8'h08, 16'hFFFF);
      w16(8'h0A, 16'hFFFF);
      wr(8'h01, (k == 2) ? 8'hC0 : 8'h40);
      i_power_down_bit <= (k == 1);
      pulse(0, (k == 2) ? 0 : 48);
      if (k < 2) begin
        i_power_down_bit <= 1'b0;
        repeat (24) @(posedge i_clock);
        rck(8'h07, 8'h80);
        r16(8'h08, 16'h0000);
        r16(8'h0A, 16'h0000);
        chk({15'h0000, o_high_irq}, 16'h0001);
        chk({15'h0000, o_low_irq}, 16'h0000);
      end else begin
        n = 0;
        while (o_cpu_reset !== 1'b1 && n < 100) begin
          @(negedge i_clock);
          n++;
        end
        n = 0;
        while (o_cpu_reset === 1'b1 && n < 100) begin
          @(negedge i_clock);
          n++;
        end
        chk(16'(n), 16'h003C);
        rck(8'h01, 8'h00);
        rck(8'h06, 8'h00);
        rck(8'h07, 8'h00);
        r16(8'h04, 16'h0000);
      end
    end
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
